// [hw/pbb_bridge.sv]
// buffering core of the processor/pci/memory bridge, with its output fifo
`timescale 1ns/100ps
// ***************
// fifo
// ***************
module pbb_fifo #(
   parameter int W     = 8,
   parameter int DEPTH = 4
) (
   // clock and reset
   input  wire logic         clk,
   input  wire logic         rstn,
   // fill side
   input  wire logic         in_valid,
   output logic              in_ready,
   input  wire logic [W-1:0] in_data,
   // drain side
   output logic              out_valid,
   input  wire logic         out_ready,
   output logic [W-1:0]      out_data
);
   localparam int AW = $clog2(DEPTH);
   logic [W-1:0] mem_q [DEPTH];
   logic [AW-1:0] wp_q, wp_d, rp_q, rp_d;
   logic [AW:0]   n_q, n_d;
   logic          wr, rd;
   always_comb
   begin
      in_ready  = n_q != (AW+1)'(DEPTH);
      out_valid = n_q != '0;
      out_data  = mem_q[rp_q];
      wr        = in_valid && in_ready;
      rd        = out_valid && out_ready;
      wp_d      = wr ? AW'((wp_q + 1'b1) % DEPTH) : wp_q;
      rp_d      = rd ? AW'((rp_q + 1'b1) % DEPTH) : rp_q;
      n_d       = n_q + (AW+1)'(wr) - (AW+1)'(rd);
   end
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         wp_q <= '0;
         rp_q <= '0;
         n_q  <= '0;
      end
      else
      begin
         wp_q <= wp_d;
         rp_q <= rp_d;
         n_q  <= n_d;
      end
   end
   // storage has no reset: contents are qualified by the count
   always_ff @(posedge clk)
   begin
      if (wr)
         mem_q[wp_q] <= in_data;
   end
endmodule : pbb_fifo

// Notes on behaviour
// [RULE1] pci side carries 32-bit address and data words, 20 to 33 mhz.
// [RULE2] pci transactions follow pci local bus revision 2.0 on both sides.
// [RULE3] processor writes to pci sit in two 16-byte write buffers first.
// [RULE4] the two write buffers run independently; consecutive writes gather into bursts.
// [RULE5] one 32-bit read buffer collects pci data for a processor read.
// [RULE6] read data goes to the processor only when full or transaction ended.
// [RULE7] two 32-byte pci-to-memory write buffers, one cache line each.
// [RULE8] write buffers alternate: one fills from pci while the other drains.
// [RULE9] one 32-byte prefetch buffer serves pci reads of memory.
// [RULE10] after a pci read completes, the next line is fetched speculatively.
// [RULE11] full buffers hold off the requester without losing any data.
module pbb_bridge import pbb_pkg::*; #(
   parameter int FIFO_D = FIFO_DEPTH
) (
   // clock and reset
   input  wire logic            clk,
   input  wire logic            rstn,
   // processor writes to pci
   input  wire logic            cw_valid,
   input  wire logic [DW-1:0]   cw_addr,
   input  wire logic [DW-1:0]   cw_data,
   output logic                 cw_ready,
   // processor reads from pci
   input  wire logic            cr_req,
   input  wire logic [DW-1:0]   cr_addr,
   output logic                 cr_ready,
   output logic                 cr_valid,
   output logic [DW-1:0]        cr_data,
   // pci initiator
   output logic                 pi_wr_valid,
   output pbb_beat_t            pi_wr,
   input  wire logic            pi_wr_ready,
   output logic                 pi_rd_req,
   output logic [DW-1:0]        pi_rd_addr,
   input  wire logic            pi_rd_dv,
   input  wire logic [DW-1:0]   pi_rd_data,
   input  wire logic [3:0]      pi_rd_be,
   input  wire logic            pi_rd_done,
   // pci target
   input  wire logic            tw_valid,
   input  wire pbb_beat_t       tw,
   output logic                 tw_ready,
   input  wire logic            tr_req,
   input  wire logic [DW-1:0]   tr_addr,
   input  wire logic            tr_end,
   output logic                 tr_ack,
   output logic [DW-1:0]        tr_data,
   // memory
   output logic                 mw_valid,
   output pbb_beat_t            mw,
   input  wire logic            mw_ready,
   output logic                 mr_req,
   output logic [DW-1:0]        mr_addr,
   input  wire logic            mr_dv,
   input  wire logic [DW-1:0]   mr_data
);
   // ***************
   // processor write gathering
   // ***************
   logic [DW-1:0] cwd_q [2][4];
   logic [DW-1:0] cwd_d [2][4];
   logic [DW-1:0] cwb_q [2];
   logic [DW-1:0] cwb_d [2];
   logic [2:0]    cwc_q [2];
   logic [2:0]    cwc_d [2];
   logic [1:0]    cwl_q, cwl_d;
   logic          cwf_q, cwf_d, cwp_q, cwp_d;
   logic [1:0]    cwi_q, cwi_d;
   logic          contig, fi_ready, push;
   pbb_beat_t     fi_data;
   always_comb
   begin
      cwd_d  = cwd_q;
      cwb_d  = cwb_q;
      cwc_d  = cwc_q;
      cwl_d  = cwl_q;
      cwf_d  = cwf_q;
      cwp_d  = cwp_q;
      cwi_d  = cwi_q;
      contig = cw_addr == cwb_q[cwf_q] + {27'h0, cwc_q[cwf_q], 2'b00};
      // a closed buffer, or a break in the address run, stalls the processor
      cw_ready = !cwl_q[cwf_q] && (cwc_q[cwf_q] == '0 ||
                 (contig && cwc_q[cwf_q] != WB_WORDS)); // RULE11
      if (cw_valid && cw_ready)
      begin
         cwd_d[cwf_q][cwc_q[cwf_q][1:0]] = cw_data; // RULE3
         if (cwc_q[cwf_q] == '0)
            cwb_d[cwf_q] = cw_addr;
         cwc_d[cwf_q] = cwc_q[cwf_q] + 3'h1;
         if (cwc_d[cwf_q] == WB_WORDS)
         begin
            cwl_d[cwf_q] = 1'b1;
            cwf_d        = !cwf_q;
         end
      end
      else if (cwc_q[cwf_q] != '0 && !cwl_q[cwf_q])
      begin
         // run broken or processor idle: close this burst, gather in the other
         cwl_d[cwf_q] = 1'b1; // RULE4
         cwf_d        = !cwf_q;
      end
      fi_data.addr = cwb_q[cwp_q] + {28'h0, cwi_q, 2'b00};
      fi_data.data = cwd_q[cwp_q][cwi_q];
      fi_data.last = {1'b0, cwi_q} == cwc_q[cwp_q] - 3'h1;
      push         = cwl_q[cwp_q] && fi_ready;
      if (push)
      begin
         cwi_d = cwi_q + 2'h1; // RULE4
         if (fi_data.last)
         begin
            cwl_d[cwp_q] = 1'b0;
            cwc_d[cwp_q] = '0;
            cwi_d        = '0;
            cwp_d        = !cwp_q;
         end
      end
   end
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         cwd_q <= '{default: '{default: '0}};
         cwb_q <= '{default: '0};
         cwc_q <= '{default: '0};
         cwl_q <= '0;
         cwf_q <= 1'b0;
         cwp_q <= 1'b0;
         cwi_q <= '0;
      end
      else
      begin
         cwd_q <= cwd_d;
         cwb_q <= cwb_d;
         cwc_q <= cwc_d;
         cwl_q <= cwl_d;
         cwf_q <= cwf_d;
         cwp_q <= cwp_d;
         cwi_q <= cwi_d;
      end
   end
   // the fifo decouples burst draining from a slow pci initiator
   pbb_fifo #(.W($bits(pbb_beat_t)), .DEPTH(FIFO_D)) u_fifo (
      .clk       (clk),
      .rstn      (rstn),
      .in_valid  (cwl_q[cwp_q]),
      .in_ready  (fi_ready),
      .in_data   (fi_data),
      .out_valid (pi_wr_valid),
      .out_ready (pi_wr_ready),
      .out_data  (pi_wr)
   );
   // ***************
   // processor read buffer
   // ***************
   pbb_rb_t       rs_q, rs_d;
   logic [DW-1:0] rbd_q, rbd_d, rbm;
   logic [3:0]    rbk_q, rbk_d;
   logic          crv_d, prq_d;
   logic [DW-1:0] pra_d, crd_d;
   always_comb
   begin
      rs_d  = rs_q;
      rbd_d = rbd_q;
      rbk_d = rbk_q;
      crv_d = 1'b0;
      crd_d = cr_data;
      prq_d = pi_rd_req;
      pra_d = pi_rd_addr;
      rbm   = rbd_q;
      cr_ready = rs_q == RB_IDLE; // RULE11
      for (int i = 0; i < 4; i++)
      begin
         if (pi_rd_be[i])
            rbm[8*i +: 8] = pi_rd_data[8*i +: 8]; // RULE1
      end
      case (rs_q)
         RB_IDLE:
         begin
            if (cr_req)
            begin
               prq_d = 1'b1; // RULE5
               pra_d = cr_addr;
               rbk_d = '0;
               rbd_d = '0;
               rs_d  = RB_WAIT;
            end
         end
         RB_WAIT:
         begin
            if (pi_rd_dv)
            begin
               rbd_d = rbm;
               rbk_d = rbk_q | pi_rd_be;
            end
            // forward only a whole word or a finished transaction
            if ((rbk_d == BE_ALL) || pi_rd_done) // RULE6 RULE2
            begin
               crv_d = 1'b1;
               crd_d = rbd_d;
               prq_d = 1'b0;
               rs_d  = RB_IDLE;
            end
         end
         default: rs_d = RB_IDLE;
      endcase
   end
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         rs_q       <= RB_IDLE;
         rbd_q      <= '0;
         rbk_q      <= '0;
         cr_valid   <= 1'b0;
         cr_data    <= '0;
         pi_rd_req  <= 1'b0;
         pi_rd_addr <= '0;
      end
      else
      begin
         rs_q       <= rs_d;
         rbd_q      <= rbd_d;
         rbk_q      <= rbk_d;
         cr_valid   <= crv_d;
         cr_data    <= crd_d;
         pi_rd_req  <= prq_d;
         pi_rd_addr <= pra_d;
      end
   end
   // ***************
   // pci to memory ping-pong write buffers
   // ***************
   logic [DW-1:0] mwd_q [2][8];
   logic [DW-1:0] mwd_d [2][8];
   logic [DW-1:0] mwb_q [2];
   logic [DW-1:0] mwb_d [2];
   logic [3:0]    mwc_q [2];
   logic [3:0]    mwc_d [2];
   logic [1:0]    mfl_q, mfl_d;
   logic          mfp_q, mfp_d, mdp_q, mdp_d;
   logic [2:0]    mwi_q, mwi_d;
   always_comb
   begin
      mwd_d = mwd_q;
      mwb_d = mwb_q;
      mwc_d = mwc_q;
      mfl_d = mfl_q;
      mfp_d = mfp_q;
      mdp_d = mdp_q;
      mwi_d = mwi_q;
      tw_ready = !mfl_q[mfp_q]; // RULE11
      if (tw_valid && tw_ready)
      begin
         mwd_d[mfp_q][mwc_q[mfp_q][2:0]] = tw.data; // RULE7
         if (mwc_q[mfp_q] == '0)
            mwb_d[mfp_q] = tw.addr;
         mwc_d[mfp_q] = mwc_q[mfp_q] + 4'h1;
         if (tw.last || mwc_d[mfp_q] == MW_WORDS)
         begin
            mfl_d[mfp_q] = 1'b1;
            mfp_d        = !mfp_q; // RULE8
         end
      end
      mw_valid = mfl_q[mdp_q];
      mw.addr  = mwb_q[mdp_q] + {27'h0, mwi_q, 2'b00};
      mw.data  = mwd_q[mdp_q][mwi_q];
      mw.last  = {1'b0, mwi_q} == mwc_q[mdp_q] - 4'h1;
      if (mw_valid && mw_ready)
      begin
         mwi_d = mwi_q + 3'h1;
         if (mw.last)
         begin
            mfl_d[mdp_q] = 1'b0; // RULE8
            mwc_d[mdp_q] = '0;
            mwi_d        = '0;
            mdp_d        = !mdp_q;
         end
      end
   end
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         mwd_q <= '{default: '{default: '0}};
         mwb_q <= '{default: '0};
         mwc_q <= '{default: '0};
         mfl_q <= '0;
         mfp_q <= 1'b0;
         mdp_q <= 1'b0;
         mwi_q <= '0;
      end
      else
      begin
         mwd_q <= mwd_d;
         mwb_q <= mwb_d;
         mwc_q <= mwc_d;
         mfl_q <= mfl_d;
         mfp_q <= mfp_d;
         mdp_q <= mdp_d;
         mwi_q <= mwi_d;
      end
   end
   // ***************
   // memory read prefetch
   // ***************
   // limitation: the line is not snooped against pci writes held above
   pbb_pf_t       ps_q, ps_d;
   logic [DW-1:0] pfd_q [8];
   logic [DW-1:0] pfd_d [8];
   logic [26:0]   pft_q, pft_d, lrt_q, lrt_d;
   logic          pfv_q, pfv_d, hit, mrq_d, tak_d;
   logic [3:0]    pfc_q, pfc_d;
   logic [DW-1:0] mra_d, trd_d;
   always_comb
   begin
      ps_d  = ps_q;
      pfd_d = pfd_q;
      pft_d = pft_q;
      lrt_d = lrt_q;
      pfv_d = pfv_q;
      pfc_d = pfc_q;
      mrq_d = 1'b0;
      mra_d = mr_addr;
      tak_d = 1'b0;
      trd_d = tr_data;
      hit   = pfv_q && pft_q == tr_addr[31:5] && pfc_q > {1'b0, tr_addr[4:2]};
      if (tr_req && hit && !tr_ack)
      begin
         tak_d = 1'b1; // RULE9
         trd_d = pfd_q[tr_addr[4:2]];
         lrt_d = pft_q;
      end
      case (ps_q)
         PF_IDLE:
         begin
            if (tr_req && !hit)
            begin
               pft_d = tr_addr[31:5];
               mrq_d = 1'b1;
            end
            else if (tr_end && pfv_q && lrt_q == pft_q && pfc_q == PF_WORDS)
            begin
               pft_d = pft_q + 27'h1; // RULE10
               mrq_d = 1'b1;
            end
            if (mrq_d)
            begin
               pfv_d = 1'b1;
               pfc_d = '0;
               mra_d = {pft_d, 5'h00};
               ps_d  = PF_FETCH;
            end
         end
         PF_FETCH:
         begin
            if (mr_dv)
            begin
               pfd_d[pfc_q[2:0]] = mr_data; // RULE9
               pfc_d = pfc_q + 4'h1;
               if (pfc_d == PF_WORDS)
                  ps_d = PF_IDLE;
            end
         end
         default: ps_d = PF_IDLE;
      endcase
   end
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         ps_q    <= PF_IDLE;
         pfd_q   <= '{default: '0};
         pft_q   <= '0;
         lrt_q   <= '0;
         pfv_q   <= 1'b0;
         pfc_q   <= '0;
         mr_req  <= 1'b0;
         mr_addr <= '0;
         tr_ack  <= 1'b0;
         tr_data <= '0;
      end
      else
      begin
         ps_q    <= ps_d;
         pfd_q   <= pfd_d;
         pft_q   <= pft_d;
         lrt_q   <= lrt_d;
         pfv_q   <= pfv_d;
         pfc_q   <= pfc_d;
         mr_req  <= mrq_d;
         mr_addr <= mra_d;
         tr_ack  <= tak_d;
         tr_data <= trd_d;
      end
   end
   // ***************
   // checks
   // ***************
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);
   sequence s_line_read_done;
      // a demand miss in the same cycle takes the fetcher first
      tr_end && !(tr_req && !hit) && ps_q == PF_IDLE && pfv_q && lrt_q == pft_q
         && pfc_q == PF_WORDS;
   endsequence
   sequence s_next_line_req;
      ##1 mr_req && mr_addr[31:5] == $past(pft_q) + 27'h1;
   endsequence
   AST_CW_DEPTH: assert property (cwc_q[0] <= WB_WORDS && cwc_q[1] <= WB_WORDS) // RULE3
      else $error("write buffer holds more than four words");
   AST_CW_STALL: assert property (cwl_q == 2'b11 |-> !cw_ready) // RULE11
      else $error("processor write taken with both buffers closed");
   AST_GATHER: assert property (push && !fi_data.last
      |=> cwp_q == $past(cwp_q) && fi_data.addr == $past(fi_data.addr) + 32'h4) // RULE4
      else $error("gathered burst not sequential");
   AST_RB_START: assert property (cr_req && cr_ready |=> pi_rd_req && !cr_ready) // RULE5
      else $error("processor read not forwarded to pci");
   AST_RB_WHOLE: assert property (cr_valid |-> $past(pi_rd_done)
      || $past(rbk_q | (pi_rd_dv ? pi_rd_be : 4'h0)) == BE_ALL) // RULE6
      else $error("read data forwarded piecemeal");
   AST_MW_LINE: assert property (tw_valid && tw_ready && mwc_q[mfp_q] == 4'h7
      |=> mfl_q[$past(mfp_q)] && mfp_q != $past(mfp_q)) // RULE7
      else $error("line buffer did not close at eight words");
   AST_PINGPONG: assert property (mw_valid && mfp_q != mdp_q && !mfl_q[mfp_q] && tw_valid
      |=> mwc_q[$past(mfp_q)] == $past(mwc_q[mfp_q]) + 4'h1) // RULE8
      else $error("pci write stalled while other buffer drains");
   AST_PF_HIT: assert property (tr_req && hit && !tr_ack
      |=> tr_ack && tr_data == pfd_q[$past(tr_addr[4:2])]) // RULE9
      else $error("prefetch hit not answered");
   AST_PF_NEXT: assert property (s_line_read_done |-> s_next_line_req) // RULE10
      else $error("next line not prefetched");
endmodule : pbb_bridge

// [hw/pbb_pkg.sv]
// constants and types shared by the bridge buffering logic
package pbb_pkg;
   // ***************
   // sizes
   // ***************
   localparam int           DW         = 32;
   localparam logic [2:0]   WB_WORDS   = 3'h4;
   localparam logic [3:0]   MW_WORDS   = 4'h8;
   localparam logic [3:0]   PF_WORDS   = 4'h8;
   localparam int           FIFO_DEPTH = 4;
   localparam logic [3:0]   BE_ALL     = 4'hF;
   localparam int           PCI_MIN_MHZ = 20;
   localparam int           PCI_MAX_MHZ = 33;
   // ***************
   // types
   // ***************
   typedef struct packed {
      logic [DW-1:0] addr;
      logic [DW-1:0] data;
      logic          last;
   } pbb_beat_t;
   typedef enum logic [1:0] {RB_IDLE = 2'b01, RB_WAIT = 2'b10} pbb_rb_t;
   typedef enum logic [1:0] {PF_IDLE = 2'b01, PF_FETCH = 2'b10} pbb_pf_t;
endpackage : pbb_pkg

// [verif/pbb_far_model.sv]
// behavioural far side: memory read port and pci read engine
`timescale 1ns/100ps
module pbb_far_model import pbb_pkg::*; (
   // clock and reset
   input  wire logic          clk,
   input  wire logic          rstn,
   // scenario control
   input  wire logic          two_beats,
   // memory read port
   input  wire logic          mr_req,
   input  wire logic [DW-1:0] mr_addr,
   output logic               mr_dv,
   output logic [DW-1:0]      mr_data,
   // pci read engine
   input  wire logic          pi_rd_req,
   input  wire logic [DW-1:0] pi_rd_addr,
   output logic               pi_rd_dv,
   output logic [DW-1:0]      pi_rd_data,
   output logic [3:0]         pi_rd_be,
   output logic               pi_rd_done
);
   // ***************
   // state
   // ***************
   logic [DW-1:0] line_q;
   logic [3:0]    mcnt_q;
   logic [2:0]    pcnt_q;
   logic [DW-1:0] v;

   function automatic logic [DW-1:0] word_at(input logic [DW-1:0] a);
      return {a[15:0] ^ 16'h5A5A, a[15:0]};
   endfunction : word_at

   assign v = word_at(pi_rd_addr);

   // idle data lines toggle so a stale word never passes for a fresh one
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         mcnt_q  <= 4'h0;
         line_q  <= 32'h0;
         mr_dv   <= 1'b0;
         mr_data <= 32'h0;
      end
      else
      begin
         mr_dv   <= 1'b0;
         mr_data <= ~mr_data;
         if (mcnt_q == 4'h0 && mr_req)
         begin
            mcnt_q <= 4'h1;
            line_q <= mr_addr;
         end
         else if (mcnt_q != 4'h0)
         begin
            mcnt_q <= (mcnt_q == 4'hB) ? 4'h0 : mcnt_q + 4'h1;
            if (mcnt_q >= 4'h4)
            begin
               mr_dv   <= 1'b1;
               mr_data <= word_at(line_q + {26'h0, mcnt_q - 4'h4, 2'b00});
            end
         end
      end
   end

   // two half-word beats, or one beat then an early end of transaction
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         pcnt_q     <= 3'h0;
         pi_rd_dv   <= 1'b0;
         pi_rd_done <= 1'b0;
         pi_rd_be   <= 4'h0;
         pi_rd_data <= 32'h0;
      end
      else
      begin
         pi_rd_dv   <= 1'b0;
         pi_rd_done <= 1'b0;
         pi_rd_be   <= 4'h0;
         pi_rd_data <= ~pi_rd_data;
         if (pcnt_q == 3'h0)
            pcnt_q <= {2'b00, pi_rd_req};
         else if (pcnt_q != 3'h5)
            pcnt_q <= pcnt_q + 3'h1;
         else if (!pi_rd_req)
            pcnt_q <= 3'h0;
         if (pcnt_q == 3'h2)
         begin
            pi_rd_dv   <= 1'b1;
            pi_rd_be   <= 4'h3;
            pi_rd_data <= {~v[31:16], v[15:0]};
         end
         if (pcnt_q == 3'h4)
         begin
            pi_rd_dv   <= two_beats;
            pi_rd_done <= !two_beats;
            pi_rd_be   <= 4'hC;
            pi_rd_data <= {v[31:16], ~v[15:0]};
         end
      end
   end
endmodule : pbb_far_model

// [verif/testbench.sv]
// self-checking bench for the bridge buffering core
`timescale 1ns/100ps
module testbench import pbb_pkg::*;;
   logic          clk = 1'b0;
   logic          rstn, cw_valid, cr_req, pi_wr_ready, pi_rd_dv, pi_rd_done, tw_valid;
   logic          tr_req, tr_end, mw_ready, mr_dv, two_beats, cw_ready, cr_ready;
   logic          cr_valid, pi_wr_valid, pi_rd_req, tw_ready, tr_ack, mw_valid, mr_req;
   logic [DW-1:0] cw_addr, cw_data, cr_addr, cr_data, pi_rd_addr, pi_rd_data;
   logic [DW-1:0] tr_addr, tr_data, mr_addr, mr_data;
   logic [3:0]    pi_rd_be;
   pbb_beat_t     pi_wr, tw, mw;
   pbb_beat_t     piq[$], mwq[$];
   logic [DW-1:0] mrq[$];
   int            n_errors = 0, total_checks = 0, n_rdb = 0, n_wait = 0;

   always #4 clk = ~clk;

   pbb_bridge pbb_bridge_inst (.clk, .rstn, .cw_valid, .cw_addr, .cw_data, .cw_ready,
      .cr_req, .cr_addr, .cr_ready, .cr_valid, .cr_data, .pi_wr_valid, .pi_wr, .pi_wr_ready,
      .pi_rd_req, .pi_rd_addr, .pi_rd_dv, .pi_rd_data, .pi_rd_be, .pi_rd_done, .tw_valid,
      .tw, .tw_ready, .tr_req, .tr_addr, .tr_end, .tr_ack, .tr_data, .mw_valid, .mw,
      .mw_ready, .mr_req, .mr_addr, .mr_dv, .mr_data);
   pbb_far_model pbb_far_model_inst (.clk, .rstn, .two_beats, .mr_req, .mr_addr, .mr_dv,
      .mr_data, .pi_rd_req, .pi_rd_addr, .pi_rd_dv, .pi_rd_data, .pi_rd_be, .pi_rd_done);

   // sampled mid-cycle, clear of both the edge and the bench's own changes
   always @(negedge clk)
   begin
      #1;
      if (rstn === 1'b1)
      begin
         if (pi_wr_valid && pi_wr_ready)
            piq.push_back(pi_wr);
         if (mw_valid && mw_ready)
            mwq.push_back(mw);
         if (mr_req)
            mrq.push_back(mr_addr);
         if (pi_rd_dv)
            n_rdb++;
      end
   end

   // ***************
   // helpers
   // ***************
   function automatic logic [DW-1:0] word_at(input logic [DW-1:0] a);
      return {a[15:0] ^ 16'h5A5A, a[15:0]};
   endfunction : word_at

   task automatic chk(input logic ok, input string msg);
      total_checks++;
      if (ok !== 1'b1)
      begin
         n_errors++;
         $display("[FAIL] %0t %s", $time, msg);
      end
   endtask : chk

   // holds the request until ready is seen before a rising edge
   task automatic hold_until(ref logic rdy, input string what);
      int n;
      n = 0;
      #1;
      while (rdy !== 1'b1 && n < 200)
      begin
         @(negedge clk);
         #1;
         n++;
      end
      n_wait += n;
      chk(n < 200, what);
      @(negedge clk);
   endtask : hold_until

   task automatic chkq(ref pbb_beat_t q[$], input logic [DW-1:0] a0, d0, input int n, per);
      logic lst;
      chk(q.size() == n, "beat count");
      for (int i = 0; i < n && i < q.size(); i++)
      begin
         lst = (i % per == per - 1) || (i == n - 1);
         chk(q[i] === {a0 + 32'(4 * i), d0 + 32'(i), lst}, "beat content");
      end
      q.delete();
   endtask : chkq

   task automatic tr_get(input logic [DW-1:0] a, output int n);
      n = 0;
      tr_req = 1'b1;
      tr_addr = a;
      @(negedge clk);
      while (tr_ack !== 1'b1 && n < 100)
      begin
         @(negedge clk);
         n++;
      end
      chk(tr_data === word_at(a), "pci read data");
      tr_req = 1'b0;
      @(negedge clk);
   endtask : tr_get

   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", total_checks, n_errors);
      if (n_errors == 0 && total_checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : tally_and_finish

   // ***************
   // scenarios
   // ***************
   task automatic t_reset();
      chk(cw_ready === 1'b1 && cr_ready === 1'b1 && tw_ready === 1'b1, "ready at reset");
      chk({cr_valid, pi_wr_valid, pi_rd_req, tr_ack, mw_valid, mr_req} === 6'h00, "idle");
      $display("test reset done");
   endtask : t_reset

   // 13 writes against a stalled pci side: both buffers fill and the writer is held
   task automatic t_gather();
      pi_wr_ready = 1'b0;
      n_wait = 0;
      fork
         begin
            repeat (40) @(negedge clk);
            pi_wr_ready = 1'b1;
         end
      join_none
      for (int i = 0; i < 13; i++)
      begin
         cw_valid = 1'b1;
         cw_addr  = 32'h0000_2000 + 32'(4 * i);
         cw_data  = 32'h1000_0000 + 32'(i);
         hold_until(cw_ready, "processor write");
      end
      cw_valid = 1'b0;
      repeat (20) @(negedge clk);
      chk(n_wait > 0, "writer never held off");
      chkq(piq, 32'h0000_2000, 32'h1000_0000, 13, 4);
      $display("test gather done");
   endtask : t_gather

   // two lines land back to back; the third waits for a drained buffer
   task automatic t_pingpong();
      mw_ready = 1'b0;
      n_wait = 0;
      fork
         begin
            repeat (30) @(negedge clk);
            mw_ready = 1'b1;
         end
      join_none
      for (int i = 0; i < 27; i++)
      begin
         tw_valid = 1'b1;
         tw = {32'h0000_4000 + 32'(4 * i), 32'h2000_0000 + 32'(i), (i % 8 == 7) || (i == 26)};
         hold_until(tw_ready, "pci write");
         if (i == 15)
            chk(n_wait == 0, "second line held off");
      end
      tw_valid = 1'b0;
      repeat (30) @(negedge clk);
      chk(n_wait > 0, "third line not held off");
      chkq(mwq, 32'h0000_4000, 32'h2000_0000, 27, 8);
      $display("test pingpong done");
   endtask : t_pingpong

   task automatic t_cread(input logic two, input logic [DW-1:0] a);
      logic [DW-1:0] v;
      int            n;
      v = word_at(a);
      n = 0;
      two_beats = two;
      n_rdb = 0;
      cr_req = 1'b1;
      cr_addr = a;
      hold_until(cr_ready, "processor read");
      cr_req = 1'b0;
      while (cr_valid !== 1'b1 && n < 100)
      begin
         @(negedge clk);
         n++;
      end
      chk(n_rdb == (two ? 2 : 1), "read forwarded early");
      chk(cr_data === (two ? v : {16'h0000, v[15:0]}), "read data");
      @(negedge clk);
      $display("test processor read done");
   endtask : t_cread

   task automatic t_prefetch();
      int n;
      mrq.delete();
      for (int i = 0; i < 8; i++)
         tr_get(32'h0000_8000 + 32'(4 * i), n);
      tr_end = 1'b1;
      @(negedge clk);
      tr_end = 1'b0;
      repeat (20) @(negedge clk);
      tr_get(32'h0000_8020, n);
      chk(n <= 1, "next line not prefetched");
      chk(mrq[0] === 32'h0000_8000, "first line fetch");
      chk(mrq.size() == 2 && mrq[1] === 32'h0000_8020, "spec fetch");
      $display("test prefetch done");
   endtask : t_prefetch

   // limit is more than ten times the expected run length
   initial
   begin
      #40000;
      n_errors++;
      $display("[FAIL] %0t watchdog expired", $time);
      tally_and_finish();
   end

   initial
   begin
      rstn = 1'b0;
      {cw_valid, cr_req, pi_wr_ready, tw_valid, tr_req, tr_end, mw_ready} = 7'h00;
      two_beats = 1'b1;
      {cw_addr, cw_data, cr_addr, tr_addr} = 128'h0;
      tw = '0;
      repeat (2) @(negedge clk);
      rstn = 1'b1;
      @(negedge clk);
      t_reset();
      t_gather();
      t_pingpong();
      t_cread(1'b1, 32'h0000_3000);
      t_cread(1'b0, 32'h0000_3004);
      t_prefetch();
      tally_and_finish();
   end
endmodule : testbench
